/* File: verilog/gpio_port_regs.vh */
// Register offsets, reset values and field constants of the pin port
`ifndef GPIO_PORT_REGS_VH
`define GPIO_PORT_REGS_VH
`define OFS_PORT_PIN_VALUE 12'h000
`define OFS_PIN_DIRECTION 12'h004
`define OFS_PAD_PULL_CONFIG 12'h008
`define OFS_IRQ_SENSE_SELECT 12'h00c
`define OFS_IRQ_DUAL_EDGE_SELECT 12'h010
`define OFS_IRQ_POLARITY_SELECT 12'h014
`define OFS_IRQ_PIN_ENABLE 12'h018
`define OFS_IRQ_RAW_FLAGS 12'h01c
`define OFS_IRQ_FLAG_CLEAR 12'h020
`define OFS_PORT_CONTROL 12'h030
`define RST_PORT_PIN_VALUE 16'h0000
`define RST_PIN_DIRECTION 16'h0000
`define RST_PAD_PULL_CONFIG 32'haaaaaaaa
`define RST_IRQ_REG 16'h0000
`define PULL_UP 2'h0
`define PULL_DOWN 2'h1
`define PULL_NONE 2'h2
`define PULL_REPEAT 2'h3
`define CTRL_MIC_SEL_BIT 0
`define INPUT_ONLY_PIN 14
`define MIC_PIN_P 7
`define MIC_PIN_N 8
`endif

/* File: verilog/gpio_port.v */
// Sixteen-pin general purpose port with pad pulls and pin interrupts
//
// Summary of operation
// - Port value reads synchronised pin levels; writes set output levels.
// - Direction bit 0 input, 1 output; all pins inputs after reset.
// - An enabled peripheral function sets its pin direction itself.
// - Pull field 00 up, 01 down, 10 none, 11 repeater.
// - Pull config register resets to 0xaaaaaaaa, every field no-pull.
// - Repeater pulls toward the level the pin currently reads.
// - Repeater retention need not survive deepest power-down.
// - Microphone select takes pins 7 and 8; software clears it first.
// - Sense bit 0 edge-sensitive, 1 level-sensitive interrupt.
// - Dual-edge bit 1 triggers on both edges; else polarity decides.
// - Polarity 0 rising or high, 1 falling or low.
// - Interrupt forwarded only while enable bit is 1; enables reset 0.
// - Raw flags show triggers regardless of enable; request needs enable.
// - Writing 1 to clear register clears that raw flag, unless a trigger sets it in the same cycle.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "gpio_port_regs.vh"
module gpio_port #(
   parameter PINS = 16,
   parameter INPUT_ONLY_MASK = 16'h4000,
   parameter MIC_PIN_MASK = 16'h0180
) (
   input wire CORE_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output wire [31:0] PRDATA,
   output wire PREADY,
   output wire PSLVERR,
   input wire [15:0] PIN_IN,
   output wire [15:0] PIN_OUT,
   output wire [15:0] PIN_OE_N,
   output wire [15:0] PULL_UP_EN,
   output wire [15:0] PULL_DOWN_EN,
   output wire [15:0] MIC_ANALOG_EN,
   input wire [15:0] PERIPH_OWN,
   input wire [15:0] PERIPH_DIR_OUT,
   input wire [15:0] PERIPH_OUT,
   output wire PORT_IRQ
);
   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rst_n;
   reg [15:0] pin_meta_reg;
   reg [15:0] pin_sync_reg;
   reg [15:0] pin_prev_reg;
   reg [15:0] port_pin_value_reg;
   reg [15:0] pin_direction_reg;
   reg [31:0] pad_pull_config_reg;
   reg [15:0] irq_sense_select_reg;
   reg [15:0] irq_dual_edge_select_reg;
   reg [15:0] irq_polarity_select_reg;
   reg [15:0] irq_pin_enable_reg;
   reg [15:0] irq_raw_flags_reg;
   reg [15:0] irq_raw_flags_next;
   reg microphone_input_select_reg;
   reg [31:0] prdata_reg;
   reg [31:0] prdata_next;
   reg [15:0] trig;
   reg [15:0] dir_eff;
   reg [15:0] pu;
   reg [15:0] pd;
   reg [1:0] fld;
   integer i;
   integer j;
   wire wr_en;
   wire rd_en;
   wire [15:0] mic_mask;

   function addr_hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         addr_hit = (a == ofs);
      end
   endfunction

   // Reset release through two flip-flops
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   assign rst_n = rst_sync_reg;

   assign wr_en = PSEL & PENABLE & PWRITE;
   assign rd_en = PSEL & ~PENABLE & ~PWRITE;
   assign PREADY = 1'b1;
   assign PSLVERR = 1'b0;
   assign PRDATA = prdata_reg;

   // Pin synchroniser and previous sample for edges
   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_reg <= 16'h0000;
         pin_sync_reg <= 16'h0000;
         pin_prev_reg <= 16'h0000;
      end else begin
         pin_meta_reg <= PIN_IN;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // Register writes
   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         port_pin_value_reg <= `RST_PORT_PIN_VALUE;
         pin_direction_reg <= `RST_PIN_DIRECTION;
         pad_pull_config_reg <= `RST_PAD_PULL_CONFIG;
         irq_sense_select_reg <= `RST_IRQ_REG;
         irq_dual_edge_select_reg <= `RST_IRQ_REG;
         irq_polarity_select_reg <= `RST_IRQ_REG;
         irq_pin_enable_reg <= `RST_IRQ_REG;
         microphone_input_select_reg <= 1'b0;
      end else if (wr_en) begin
         if (addr_hit(PADDR, `OFS_PORT_PIN_VALUE))
            port_pin_value_reg <= PWDATA[15:0];
         if (addr_hit(PADDR, `OFS_PIN_DIRECTION))
            pin_direction_reg <= PWDATA[15:0];
         if (addr_hit(PADDR, `OFS_PAD_PULL_CONFIG))
            pad_pull_config_reg <= PWDATA;
         if (addr_hit(PADDR, `OFS_IRQ_SENSE_SELECT))
            irq_sense_select_reg <= PWDATA[15:0];
         if (addr_hit(PADDR, `OFS_IRQ_DUAL_EDGE_SELECT))
            irq_dual_edge_select_reg <= PWDATA[15:0];
         if (addr_hit(PADDR, `OFS_IRQ_POLARITY_SELECT))
            irq_polarity_select_reg <= PWDATA[15:0];
         if (addr_hit(PADDR, `OFS_IRQ_PIN_ENABLE))
            irq_pin_enable_reg <= PWDATA[15:0];
         if (addr_hit(PADDR, `OFS_PORT_CONTROL))
            microphone_input_select_reg <= PWDATA[`CTRL_MIC_SEL_BIT];
      end
   end

   // Trigger detection per pin
   always @* begin
      for (i = 0; i < PINS; i = i + 1) begin
         if (irq_sense_select_reg[i])
            trig[i] = pin_sync_reg[i] ^ irq_polarity_select_reg[i];
         else if (irq_dual_edge_select_reg[i])
            trig[i] = pin_sync_reg[i] ^ pin_prev_reg[i];
         else if (irq_polarity_select_reg[i])
            trig[i] = pin_prev_reg[i] & ~pin_sync_reg[i];
         else
            trig[i] = ~pin_prev_reg[i] & pin_sync_reg[i];
      end
   end

   // Raw flags: set wins over clear; level mode re-sets each cycle
   always @* begin
      irq_raw_flags_next = irq_raw_flags_reg;
      if (wr_en && addr_hit(PADDR, `OFS_IRQ_FLAG_CLEAR))
         irq_raw_flags_next = irq_raw_flags_reg & ~PWDATA[15:0];
      irq_raw_flags_next = irq_raw_flags_next | trig;
   end

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n)
         irq_raw_flags_reg <= `RST_IRQ_REG;
      else
         irq_raw_flags_reg <= irq_raw_flags_next;
   end

   assign PORT_IRQ = |(irq_raw_flags_reg & irq_pin_enable_reg);

   // Read data captured in the setup cycle
   always @* begin
      prdata_next = 32'h00000000;
      case (PADDR)
         `OFS_PORT_PIN_VALUE: prdata_next[15:0] = pin_sync_reg;
         `OFS_PIN_DIRECTION: prdata_next[15:0] = pin_direction_reg;
         `OFS_PAD_PULL_CONFIG: prdata_next = pad_pull_config_reg;
         `OFS_IRQ_SENSE_SELECT: prdata_next[15:0] = irq_sense_select_reg;
         `OFS_IRQ_DUAL_EDGE_SELECT: begin
            prdata_next[15:0] = irq_dual_edge_select_reg;
         end
         `OFS_IRQ_POLARITY_SELECT: begin
            prdata_next[15:0] = irq_polarity_select_reg;
         end
         `OFS_IRQ_PIN_ENABLE: prdata_next[15:0] = irq_pin_enable_reg;
         `OFS_IRQ_RAW_FLAGS: prdata_next[15:0] = irq_raw_flags_reg;
         `OFS_PORT_CONTROL: begin
            prdata_next[`CTRL_MIC_SEL_BIT] = microphone_input_select_reg;
         end
         default: prdata_next = 32'h00000000;
      endcase
   end

   always @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n)
         prdata_reg <= 32'h00000000;
      else if (rd_en)
         prdata_reg <= prdata_next;
   end

   // Pin drive: peripheral overrides, microphone takeover, input-only pin
   assign mic_mask = microphone_input_select_reg ? MIC_PIN_MASK : 16'h0000;
   assign MIC_ANALOG_EN = mic_mask;

   always @* begin
      dir_eff = (PERIPH_OWN & PERIPH_DIR_OUT) |
                (~PERIPH_OWN & pin_direction_reg);
      dir_eff = dir_eff & ~mic_mask & ~INPUT_ONLY_MASK;
   end

   assign PIN_OE_N = ~dir_eff;
   assign PIN_OUT = (PERIPH_OWN & PERIPH_OUT) |
                    (~PERIPH_OWN & port_pin_value_reg);

   // Pad pull selection
   always @* begin
      fld = 2'b00;
      for (j = 0; j < PINS; j = j + 1) begin
         fld = pad_pull_config_reg[2*j +: 2];
         case (fld)
            `PULL_UP: begin
               pu[j] = 1'b1;
               pd[j] = 1'b0;
            end
            `PULL_DOWN: begin
               pu[j] = 1'b0;
               pd[j] = 1'b1;
            end
            `PULL_REPEAT: begin
               // Kept level lives in reset flops, lost on power-down
               pu[j] = pin_sync_reg[j];
               pd[j] = ~pin_sync_reg[j];
            end
            default: begin
               pu[j] = 1'b0;
               pd[j] = 1'b0;
            end
         endcase
      end
   end

   assign PULL_UP_EN = pu & ~mic_mask;
   assign PULL_DOWN_EN = pd & ~mic_mask;
endmodule

/* File: tb/gpio_port_checker.sv */
// Boundary assertions of the pin port
`timescale 1ns/1ps
module gpio_port_checker (
   input wire CORE_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PRDATA,
   input wire [15:0] PIN_IN,
   input wire [15:0] PIN_OE_N,
   input wire [15:0] PULL_UP_EN,
   input wire [15:0] PULL_DOWN_EN,
   input wire [15:0] MIC_ANALOG_EN,
   input wire [15:0] PERIPH_OWN,
   input wire [15:0] PERIPH_DIR_OUT,
   input wire PORT_IRQ
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   wire [15:0] own_m = PERIPH_OWN & ~MIC_ANALOG_EN & 16'hbfff;
   property p_periph_dir; ((PIN_OE_N ^ ~PERIPH_DIR_OUT) & own_m) == 16'h0;
   endproperty
   a_periph_dir: assert property (p_periph_dir) else $error("own dir");
   property p_input_only; PIN_OE_N[14] == 1'b1; endproperty
   a_input_only: assert property (p_input_only) else $error("pin 14");
   property p_pull_excl; (PULL_UP_EN & PULL_DOWN_EN) == 16'h0; endproperty
   a_pull_excl: assert property (p_pull_excl) else $error("pulls");
   property p_mic_pins; MIC_ANALOG_EN inside {16'h0, 16'h0180}; endproperty
   a_mic_pins: assert property (p_mic_pins) else $error("mic pins");
   property p_read_pins; (PSEL && !PENABLE && !PWRITE && PADDR == 12'h0)
      |=> PRDATA == {16'h0, $past(PIN_IN, 3)}; endproperty
   a_read_pins: assert property (p_read_pins) else $error("pin read");
   property p_irq_reset; $rose(RST_N) |-> !PORT_IRQ [*4]; endproperty
   a_irq_reset: assert property (p_irq_reset) else $error("irq");
   property p_pull_reset;
      $rose(RST_N) |-> (PULL_UP_EN == 16'h0 && PULL_DOWN_EN == 16'h0) [*3];
   endproperty
   a_pull_reset: assert property (p_pull_reset) else $error("pull rst");
   property p_dir_reset; $rose(RST_N) |-> (PIN_OE_N == 16'hffff) [*3];
   endproperty
   a_dir_reset: assert property (p_dir_reset) else $error("dir rst");
   c_flags: cover property (PSEL && PENABLE && PADDR == 12'h01c);
   c_irq: cover property (PORT_IRQ);
   c_mic: cover property (MIC_ANALOG_EN != 16'h0);
endmodule
bind gpio_port gpio_port_checker i_gpio_port_checker (.*);

/* File: tb/gpio_pins_model.sv */
// Board-side model of the sixteen pins
`timescale 1ns/1ps
module gpio_pins_model (
   input wire clk,
   input wire [15:0] pin_out,
   input wire [15:0] oe_n,
   input wire [15:0] pull_up,
   input wire [15:0] pull_down,
   input wire [15:0] ext_en,
   input wire [15:0] ext_val,
   output wire [15:0] level
);
   reg [15:0] flt = 16'h0;
   always @(posedge clk) flt <= ~flt;
   // Undriven pins take ext_val where ext_en is set, else follow the pulls or float with a changing level
   assign level = (~oe_n & pin_out) | (oe_n & ext_en & ext_val) |
      (oe_n & ~ext_en & (pull_up | (~pull_down & flt)));
endmodule

/* File: tb/gpio_port_with_pin_interrupts_tb.sv */
// Self-checking bench for the pin port
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
   num_errors++; $display("BAD %s exp %h got %h", n, e, a); end end
module gpio_port_with_pin_interrupts_tb;
   logic CORE_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, r, e_m;
   logic [15:0] PERIPH_OWN = 16'h0, PERIPH_DIR_OUT = 16'h0, PERIPH_OUT = 16'h0;
   logic [15:0] ext_en = 16'hffff, ext_val = 16'h0, dir;
   wire [31:0] PRDATA;
   wire PREADY, PSLVERR, PORT_IRQ;
   wire [15:0] PIN_IN, PIN_OUT, PIN_OE_N, PULL_UP_EN, PULL_DOWN_EN;
   wire [15:0] MIC_ANALOG_EN;
   logic [31:0] exp_q[$];
   logic [4:0] tbl [5] = '{5'h02, 5'h04, 5'h0e, 5'h13, 5'h16};
   int num_errors = 0, n_compared = 0, m, p;
   gpio_port i_gpio_port (.*);
   gpio_pins_model i_gpio_pins_model (.clk(CORE_CLK), .pin_out(PIN_OUT),
      .oe_n(PIN_OE_N), .pull_up(PULL_UP_EN), .pull_down(PULL_DOWN_EN),
      .ext_en(ext_en), .ext_val(ext_val), .level(PIN_IN));
   initial forever #5 CORE_CLK = ~CORE_CLK;
   task automatic stop_test();
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      int k = 0;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge CORE_CLK);
         k++;
      end while (PREADY !== 1'b1 && k < 20);
      if (k == 20) begin
         num_errors++;
         stop_test();
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CORE_CLK);
   endtask
   task automatic rd(logic [11:0] a, logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   always @(posedge CORE_CLK) begin
      if (PSEL && PENABLE && !PWRITE && PREADY === 1'b1) begin
         e_m = exp_q.pop_front();
         `CHK("read", e_m, PRDATA)
         `CHK("slverr", 1'b0, PSLVERR)
      end
   end
   initial begin
      void'($urandom(32'h45fe42a3));
      repeat (6) @(posedge CORE_CLK);
      RST_N <= 1'b1;
      repeat (3) @(posedge CORE_CLK);
      for (m = 0; m < 7; m++) rd(12'(m * 4), m == 2 ? 32'haaaaaaaa : 0);
      rd(12'h03c, 32'h0);
      r = $urandom;
      dir = r[15:0] & 16'hbfff;
      ext_en <= ~dir;
      apb(1'b1, 12'h004, {~r[31:16], dir});
      apb(1'b1, 12'h000, ~r);
      repeat (3) @(posedge CORE_CLK);
      rd(12'h000, {16'h0, ~r[15:0] & dir});
      rd(12'h004, {16'h0, dir});
      apb(1'b1, 12'h004, 32'h0);
      ext_en <= 16'hffff;
      ext_val <= 16'h0008;
      apb(1'b1, 12'h008, 32'haaaaaae4);
      ext_en <= 16'hfff4;
      repeat (4) @(negedge CORE_CLK);
      `CHK("pull up", 16'h0009, PULL_UP_EN)
      `CHK("pull down", 16'h0002, PULL_DOWN_EN)
      @(posedge CORE_CLK);
      rd(12'h000, 32'h0009);
      ext_en <= 16'hffff;
      ext_val <= 16'h0;
      p = $urandom_range(15);
      for (m = 0; m < 5; m++) begin
         apb(1'b1, 12'h00c, {31'h0, tbl[m][4]} << p);
         apb(1'b1, 12'h010, {31'h0, tbl[m][3]} << p);
         apb(1'b1, 12'h014, {31'h0, tbl[m][2]} << p);
         apb(1'b1, 12'h018, {31'h0, m % 2 == 0} << p);
         apb(1'b1, 12'h020, 32'hffff);
         ext_val[p] <= 1'b1;
         repeat (5) @(posedge CORE_CLK);
         apb(1'b1, 12'h020, ~(32'h1 << p));
         rd(12'h01c, {31'h0, tbl[m][1]} << p);
         `CHK("irq", tbl[m][1] & (m % 2 == 0), PORT_IRQ)
         apb(1'b1, 12'h020, 32'h1 << p);
         rd(12'h01c, {31'h0, tbl[m][0]} << p);
         ext_val[p] <= 1'b0;
         repeat (4) @(posedge CORE_CLK);
      end
      apb(1'b1, 12'h018, 32'h0);
      `CHK("irq off", 1'b0, PORT_IRQ)
      r = $urandom;
      PERIPH_OWN <= r[15:0];
      PERIPH_DIR_OUT <= r[31:16];
      PERIPH_OUT <= r[23:8];
      ext_en <= ~(r[15:0] & r[31:16]);
      @(negedge CORE_CLK);
      `CHK("oe", ~(r[15:0] & r[31:16]) | 16'h4000, PIN_OE_N)
      @(posedge CORE_CLK);
      apb(1'b1, 12'h030, 32'h1);
      `CHK("mic", 16'h0180, MIC_ANALOG_EN)
      apb(1'b1, 12'h030, 32'h0);
      `CHK("mic off", 16'h0, MIC_ANALOG_EN)
      stop_test();
   end
endmodule
